// ==== hdl/pdlc_top.v ====
// Duty-limit clamp, saturation feed-forward and third-order compensation filter
`timescale 1ns/100ps
`include "pdlc_map.vh"
module pdlc_top #(
  parameter ERR_W    = 8,
  parameter SAT_WIN  = 8'sd32,
  parameter SHARE_W  = 8
) (
  input  wire               clk_sys,
  input  wire               rst_n,
  input  wire               reg_wr,
  input  wire [3:0]         reg_addr,
  input  wire [7:0]         reg_wdata,
  input  wire [3:0]         reg_raddr,
  output reg  [7:0]         reg_rdata,
  input  wire               sw_tick,
  input  wire [ERR_W-1:0]   err_in,
  input  wire [SHARE_W-1:0] share_in,
  output reg  [SHARE_W-1:0] share_out,
  input  wire [SHARE_W-1:0] own_current,
  output reg  [5:0]         duty_out,
  output reg                sat_active
);
  localparam ACC_W = `PDLC_ACC_W;

  // ----------------------------------------------------------
  // Control register and coefficient store
  // ----------------------------------------------------------
  reg  [7:0] limit_reg_r;
  reg  [7:0] coef_r [0:10];
  wire [7:0] mem_rd;
  integer    k;

  // Write decode shared by the limit byte and the coefficient shadow
  wire       lim_wr   = reg_wr && (reg_addr == `PDLC_REG_LIMIT);
  wire       coef_wr  = reg_wr && (reg_addr >= `PDLC_REG_C0H) && (reg_addr <= `PDLC_REG_B3);
  wire [3:0] coef_idx = reg_addr - `PDLC_REG_C0H; // Index 0 is the first numerator high byte

  // Limit register write from the serial bus side
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      limit_reg_r <= `PDLC_LIMIT_RST;
    end else if (lim_wr) begin
      limit_reg_r <= reg_wdata;
    end
  end

  // Shadow copy of the eleven coefficients for the datapath
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (k = 0; k < 11; k = k + 1) begin
        coef_r[k] <= `PDLC_COEF_RST;
      end
    end else if (coef_wr) begin
      coef_r[coef_idx] <= reg_wdata;
    end
  end

  pdlc_regfile #(
    .DEPTH (`PDLC_REG_COUNT),
    .AW    (4)
  ) u_regs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (reg_wr),
    .wr_addr (reg_addr),
    .wr_data (reg_wdata),
    .rd_addr (reg_raddr),
    .rd_data (mem_rd)
  );

  // Read data passes straight from the memory's output register
  always @* begin
    reg_rdata = mem_rd;
  end

  // ----------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------
  wire [5:0] duty_limit_field = limit_reg_r[`PDLC_LIM_MSB:`PDLC_LIM_LSB];
  wire       sat_high_enable  = limit_reg_r[`PDLC_SATHI_BIT];
  wire       sat_low_enable   = limit_reg_r[`PDLC_SATLO_BIT];

  // Signed 16-bit coefficient from a high/low pair
  function signed [15:0] pair16;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair16 = {hi, lo};
    end
  endfunction

  // Sign-extended product truncated to the accumulator width
  function signed [ACC_W-1:0] mulc;
    input signed [15:0]      c;
    input signed [ACC_W-1:0] x;
    reg   signed [ACC_W+15:0] p;
    begin
      p    = c * x;
      mulc = p[ACC_W-1+`PDLC_FRAC:`PDLC_FRAC];
    end
  endfunction

  // Sign-extend an 8-bit denominator coefficient
  function signed [15:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{8{v[7]}}, v};
    end
  endfunction

  wire signed [15:0] c0 = pair16(coef_r[0], coef_r[1]);
  wire signed [15:0] c1 = pair16(coef_r[2], coef_r[3]);
  wire signed [15:0] c2 = pair16(coef_r[4], coef_r[5]);
  wire signed [15:0] c3 = pair16(coef_r[6], coef_r[7]);
  wire signed [15:0] b1 = sext8(coef_r[8]);
  wire signed [15:0] b2 = sext8(coef_r[9]);
  wire signed [15:0] b3 = sext8(coef_r[10]);

  // ----------------------------------------------------------
  // Current-share correction of the error
  // ----------------------------------------------------------
  wire signed [SHARE_W:0]   share_diff = $signed({1'b0, share_in}) - $signed({1'b0, own_current});
  wire signed [ERR_W-1:0]   err_s      = err_in;
  // Both terms are signed nets so the shift below keeps the sign
  wire signed [ACC_W-1:0]   err_ext    = {{(ACC_W-ERR_W){err_s[ERR_W-1]}}, err_s};
  wire signed [ACC_W-1:0]   share_ext  = {{(ACC_W-SHARE_W-1){share_diff[SHARE_W]}}, share_diff};
  wire signed [ACC_W-1:0]   err_corr   = err_ext + (share_ext >>> `PDLC_SHARE_SHIFT);

  // ----------------------------------------------------------
  // Third-order filter history
  // ----------------------------------------------------------
  reg signed [ACC_W-1:0] x1_r, x2_r, x3_r;
  reg signed [ACC_W-1:0] y1_r, y2_r, y3_r;
  reg signed [ACC_W-1:0] y_nxt;

  // Individual taps, each rescaled from its Q.6 product
  wire signed [ACC_W-1:0] tap_c0 = mulc(c0, err_corr);
  wire signed [ACC_W-1:0] tap_c1 = mulc(c1, x1_r);
  wire signed [ACC_W-1:0] tap_c2 = mulc(c2, x2_r);
  wire signed [ACC_W-1:0] tap_c3 = mulc(c3, x3_r);
  wire signed [ACC_W-1:0] tap_b1 = mulc(b1, y1_r);
  wire signed [ACC_W-1:0] tap_b2 = mulc(b2, y2_r);
  wire signed [ACC_W-1:0] tap_b3 = mulc(b3, y3_r);

  // Direct form: four feed-forward taps, three feedback taps
  always @* begin
    y_nxt = tap_c0 + tap_c1 + tap_c2 + tap_c3 - tap_b1 - tap_b2 - tap_b3;
  end

  // ----------------------------------------------------------
  // Saturation window and clamp
  // ----------------------------------------------------------
  wire over_high = err_s >  $signed(SAT_WIN);
  wire over_low  = err_s < -$signed(SAT_WIN);
  reg  [5:0] duty_nxt;
  reg        sat_nxt;

  // Clamp a filter result between zero and the programmed limit
  function [5:0] clamp6;
    input signed [ACC_W-1:0] y;
    input        [5:0]       lim;
    begin
      if (y[ACC_W-1]) begin
        clamp6 = 6'h00;
      end else if (y > $signed({{(ACC_W-6){1'b0}}, lim})) begin
        clamp6 = lim;
      end else begin
        clamp6 = y[5:0];
      end
    end
  endfunction

  // Select feed-forward extreme or clamped filter output
  always @* begin
    sat_nxt = 1'b0;
    if (sat_high_enable && over_high) begin
      duty_nxt = duty_limit_field;
      sat_nxt  = 1'b1;
    end else if (sat_low_enable && over_low) begin
      duty_nxt = 6'h00;
      sat_nxt  = 1'b1;
    end else begin
      duty_nxt = clamp6(y_nxt, duty_limit_field);
    end
  end

  // ----------------------------------------------------------
  // Filter history
  // ----------------------------------------------------------
  // Advance once per switching cycle; feedback sees the clamped duty
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      x1_r <= {ACC_W{1'b0}};
      x2_r <= {ACC_W{1'b0}};
      x3_r <= {ACC_W{1'b0}};
      y1_r <= {ACC_W{1'b0}};
      y2_r <= {ACC_W{1'b0}};
      y3_r <= {ACC_W{1'b0}};
    end else if (sw_tick) begin
      x1_r <= err_corr;
      x2_r <= x1_r;
      x3_r <= x2_r;
      y1_r <= {{(ACC_W-6){1'b0}}, duty_nxt};
      y2_r <= y1_r;
      y3_r <= y2_r;
    end
  end

  // ----------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------
  // Loaded on the same switching edge as the history
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      duty_out   <= 6'h00;
      sat_active <= 1'b0;
      share_out  <= {SHARE_W{1'b0}};
    end else if (sw_tick) begin
      duty_out   <= duty_nxt;
      sat_active <= sat_nxt;
      share_out  <= own_current;
    end
  end
endmodule // pdlc_top

// ==== hdl/pdlc_map.vh ====
// Constants for the PWM duty-limit and compensation block
// Contract
// - Limit register bits 7:2 hold duty limit code n, max duty n/64.
// - Limit register bit 1 enables high-side saturation feed-forward.
// - Limit register bit 0 enables low-side saturation feed-forward.
// - Error outside window with saturation enabled jumps duty to limit or zero.
// - Error inside window changes duty gradually through the filter.
// - Third-order filter with four numerator and three denominator coefficients.
// - Numerator coefficients in high/low register pairs; eleven coefficient registers.
// - Limit and saturation register writable by the host over the serial bus.
// - Paralleled units exchange a digital current-share value and converge.
`ifndef PDLC_MAP_VH
`define PDLC_MAP_VH
// ------------------------------------------------------------
// Register indexes
// ------------------------------------------------------------
`define PDLC_REG_LIMIT   4'h0
`define PDLC_REG_C0H     4'h1
`define PDLC_REG_C0L     4'h2
`define PDLC_REG_C1H     4'h3
`define PDLC_REG_C1L     4'h4
`define PDLC_REG_C2H     4'h5
`define PDLC_REG_C2L     4'h6
`define PDLC_REG_C3H     4'h7
`define PDLC_REG_C3L     4'h8
`define PDLC_REG_B1      4'h9
`define PDLC_REG_B2      4'ha
`define PDLC_REG_B3      4'hb
`define PDLC_REG_COUNT   12
// ------------------------------------------------------------
// Limit register fields and reset values
// ------------------------------------------------------------
`define PDLC_LIM_MSB     7
`define PDLC_LIM_LSB     2
`define PDLC_SATHI_BIT   1
`define PDLC_SATLO_BIT   0
`define PDLC_LIMIT_RST   8'h00
`define PDLC_COEF_RST    8'h00
// ------------------------------------------------------------
// Arithmetic
// ------------------------------------------------------------
`define PDLC_DUTY_W      6
`define PDLC_ACC_W       24
`define PDLC_FRAC        6
`define PDLC_SHARE_SHIFT 2
`endif

// ==== hdl/pdlc_regfile.v ====
// Small register memory holding the eleven filter coefficients and the limit byte
`timescale 1ns/100ps
module pdlc_regfile #(
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data
);
  reg [7:0] mem_r [0:DEPTH-1];
  integer   i;

  // ----------------------------------------------------------
  // Storage with registered read port
  // ----------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en && (wr_addr < DEPTH)) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= (rd_addr < DEPTH) ? mem_r[rd_addr] : 8'h00;
    end
  end
endmodule // pdlc_regfile

// ==== test/pdlc_peer.sv ====
// Model of a paralleled converter on the current-share line
`timescale 1ns/100ps
module pdlc_peer (
  input  wire       clk_sys,
  input  wire [7:0] level,
  output reg  [7:0] share_in
);
  // Publishes its own current on the shared line every cycle
  initial share_in = 8'h00;
  always @(posedge clk_sys) begin
    share_in <= level;
  end
endmodule // pdlc_peer

// ==== test/pdlc_top_asserts.sv ====
// Assertion checker for the duty-limit and saturation block
`timescale 1ns/100ps
module pdlc_chk #(
  parameter ERR_W   = 8,
  parameter SHARE_W = 8
) (
  input wire               clk_sys,
  input wire               rst_n,
  input wire               reg_wr,
  input wire [3:0]         reg_addr,
  input wire [7:0]         reg_wdata,
  input wire [3:0]         reg_raddr,
  input wire [7:0]         reg_rdata,
  input wire               sw_tick,
  input wire [ERR_W-1:0]   err_in,
  input wire [SHARE_W-1:0] share_in,
  input wire [SHARE_W-1:0] share_out,
  input wire [SHARE_W-1:0] own_current,
  input wire [5:0]         duty_out,
  input wire               sat_active
);
  reg  [7:0]              lim_r;
  wire [5:0]              lim_c = lim_r[7:2];
  wire signed [ERR_W-1:0] err_s = err_in;
  wire                    quiet = share_in == own_current;
  // Shadow of the limit register
  always @(posedge clk_sys) begin
    if (!rst_n) lim_r <= 8'h00;
    else if (reg_wr && reg_addr == 4'h0) lim_r <= reg_wdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CLAMP: assert property (sw_tick |=> duty_out <= $past(lim_c)) else $error("duty above limit");
  AST_SAT_HI: assert property (sw_tick && quiet && lim_r[1] && err_s > 32
    |=> duty_out == $past(lim_c) && sat_active) else $error("high saturation missed");
  AST_SAT_LO: assert property (sw_tick && quiet && lim_r[0] && err_s < -32
    |=> duty_out == 6'h00 && sat_active) else $error("low saturation missed");
  AST_IN_WIN: assert property (sw_tick && quiet && err_s <= 32 && err_s >= -32
    |=> !sat_active) else $error("saturation inside window");
  AST_SAT_OFF: assert property (sw_tick && lim_r[1:0] == 2'b00 |=> !sat_active) else $error("saturation while off");
  AST_RD_LIM: assert property (reg_raddr == 4'h0 && !reg_wr |=> reg_rdata == $past(lim_r)) else $error("limit readback");
  AST_RD_UNMAP: assert property (reg_raddr > 4'hb |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_SHARE: assert property (sw_tick |=> share_out == $past(own_current)) else $error("share value not published");
  COV_HI: cover property (sw_tick && lim_r[1] && err_s > 32);
  COV_LO: cover property (sw_tick && lim_r[0] && err_s < -32);
  COV_UNMAP: cover property (reg_raddr > 4'hb);
endmodule // pdlc_chk
bind pdlc_top pdlc_chk #(.ERR_W(ERR_W), .SHARE_W(SHARE_W)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
  .sw_tick(sw_tick), .err_in(err_in), .share_in(share_in), .share_out(share_out), .own_current(own_current),
  .duty_out(duty_out), .sat_active(sat_active));

// ==== test/tb_top.sv ====
// Self-checking bench for the duty-limit and saturation block
`timescale 1ns/100ps
module tb_top;
  reg         clk_sys, rst_n, reg_wr, sw_tick;
  reg  [3:0]  reg_addr, reg_raddr;
  reg  [7:0]  reg_wdata, err_in, own_current, level;
  wire [7:0]  reg_rdata, share_in, share_out;
  wire [5:0]  duty_out;
  wire        sat_active;
  integer     fail_count, samples_checked, i;
  reg  [31:0] rnd;
  reg  [7:0]  mem [0:15];
  reg  [23:0] lim_tab = {6'd63, 6'd32, 6'd1, 6'd0};
  longint     xh[$], yh[$];
  pdlc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_raddr(reg_raddr), .reg_rdata(reg_rdata), .sw_tick(sw_tick), .err_in(err_in), .share_in(share_in),
    .share_out(share_out), .own_current(own_current), .duty_out(duty_out), .sat_active(sat_active));
  pdlc_peer peer_u (.clk_sys(clk_sys), .level(level), .share_in(share_in));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Filter model: Q.6 taps, 24-bit wrap, clamped duty fed back
  function longint w24(input longint v);
    w24 = {{40{v[23]}}, v[23:0]};
  endfunction
  function longint tap(input longint c, input longint x);
    tap = w24((c * x) >>> 6);
  endfunction
  function longint cpair(input integer a);
    cpair = $signed({mem[a], mem[a + 1]});
  endfunction
  function longint cden(input integer a);
    cden = $signed(mem[a]);
  endfunction
  task end_of_test; begin
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  task cmp(input [63:0] what, input [7:0] exp, input [7:0] got); begin
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0s expected %h seen %h", what, exp, got);
    end
  end endtask
  task wr(input [3:0] a, input [7:0] d); begin
    @(negedge clk_sys); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    if (a < 4'hc) mem[a] = d;
    @(negedge clk_sys); reg_wr = 1'b0;
  end endtask
  task rd(input [3:0] a); begin
    @(negedge clk_sys); reg_raddr = a;
    @(negedge clk_sys); cmp("rdata", mem[a], reg_rdata);
  end endtask
  // One switching cycle, then the model's verdict on duty and flag
  task tick(input [7:0] e, input [7:0] s, input [7:0] o);
    integer ev, sd, dm, sm, lim;
    longint corr, yn;
    begin
    ev = $signed(e);
    sd = s - o;
    corr = ev + (sd >>> 2);
    lim = mem[0][7:2];
    yn = w24(tap(cpair(1), corr) + tap(cpair(3), xh[0]) + tap(cpair(5), xh[1]) + tap(cpair(7), xh[2])
      - tap(cden(9), yh[0]) - tap(cden(10), yh[1]) - tap(cden(11), yh[2]));
    sm = (mem[0][1] && ev > 32) || (mem[0][0] && ev < -32);
    if (mem[0][1] && ev > 32) dm = lim;
    else if (sm || yn < 0) dm = 0;
    else if (yn > lim) dm = lim;
    else dm = yn[5:0];
    xh.push_front(corr);
    xh.delete(3);
    yh.push_front(dm);
    yh.delete(3);
    @(negedge clk_sys); level = s; own_current = o;
    @(negedge clk_sys); sw_tick = 1'b1; err_in = e;
    @(negedge clk_sys); sw_tick = 1'b0;
    cmp("clamp", 8'h01, {7'h00, duty_out <= mem[0][7:2]});
    cmp("share", o, share_out);
    if (s == o && mem[0][1] && ev > 32) cmp("duty", {2'b00, mem[0][7:2]}, {2'b00, duty_out});
    else if (s == o && mem[0][0] && ev < -32) cmp("duty", 8'h00, {2'b00, duty_out});
    if (s == o) cmp("sat", {7'h00, (mem[0][1] && ev > 32) || (mem[0][0] && ev < -32)}, {7'h00, sat_active});
    cmp("fduty", dm[7:0], {2'b00, duty_out});
    cmp("fsat", sm[7:0], {7'h00, sat_active});
  end endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Watchdog against a hung simulation run
  initial begin
    #400000;
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; sw_tick = 1'b0; reg_addr = 4'h0; reg_raddr = 4'h0; reg_wdata = 8'h00;
    err_in = 8'h00; own_current = 8'h00; level = 8'h00;
    fail_count = 0; samples_checked = 0; rnd = 32'h14921f55;
    for (i = 0; i < 16; i = i + 1) mem[i] = 8'h00;
    for (i = 0; i < 3; i = i + 1) begin
      xh.push_back(0);
      yh.push_back(0);
    end
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    for (i = 0; i < 16; i = i + 1) rd(i[3:0]);
    for (i = 0; i < 16; i = i + 1) begin
      rnd = lfsr(rnd);
      wr(i[3:0], rnd[7:0]);
    end
    for (i = 0; i < 16; i = i + 1) rd(i[3:0]);
    // Every limit code class with every enable pair
    for (i = 0; i < 16; i = i + 1) begin
      rnd = lfsr(rnd);
      wr(4'h0, {lim_tab[i[3:2]*6 +: 6], i[1:0]});
      rd(4'h0);
      tick(8'h64, rnd[7:0], rnd[7:0]);
      tick({{3{rnd[12]}}, rnd[12:8]}, rnd[7:0], rnd[7:0]);
      tick(8'h9c, rnd[7:0], rnd[7:0]);
      tick(rnd[23:16], rnd[31:24], rnd[7:0]);
    end
    // Host practice: limit near 130 percent of steady duty, saturation off
    wr(4'h0, 8'h68);
    for (i = 0; i < 4; i = i + 1) tick(8'h10, 8'h40, 8'h40);
    end_of_test;
  end
endmodule // tb_top
